// [sim/mem_model.sv]
// Purpose: Memory answering the transfer channel port of the shell.
// Assumes: One request at a time, held until acknowledged.
// Notes:   Latency is set by the bench; loads return the inverted address.
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Memory port
  input  wire pshell_pkg::mem_req_s        mem_req,
  output logic                             mem_ack,
  output logic [pshell_pkg::DATA_W-1:0]    mem_rdata,
  // Wait cycles before each acknowledge
  input  wire logic [3:0]                  lat
);
  import pshell_pkg::*;
  logic [3:0]        wait_cnt;   // Cycles waited on current request
  logic [DATA_W-1:0] last_addr;  // Address of last store
  logic [DATA_W-1:0] last_data;  // Data of last store

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge after the chosen latency, record stores
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
      mem_rdata <= 32'h5555_aaaa;
    end else if (mem_ack) begin
      // Request ends at this edge; data line no longer valid
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req.valid && wait_cnt == lat) begin
      mem_ack   <= 1'b1;
      wait_cnt  <= 4'h0;
      mem_rdata <= ~mem_req.addr;
      if (mem_req.write) begin
        last_addr <= mem_req.addr;
        last_data <= mem_req.wdata;
      end
    end else begin
      // Idle or stalling: toggle read data so stale values never match
      wait_cnt  <= mem_req.valid ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the peripheral register shell.
// Assumes: Default window base, 16 KB window, one byte per move.
// Notes:   Inputs change on the falling edge of the clock.
`timescale 1ns/1ps
module tb_top;
  import pshell_pkg::*;
  localparam logic [31:0] BA = 32'hfffc_0000;  // Window base
  logic        sys_clk = 1'b0;                 // 100 MHz clock
  logic        sys_rst = 1'b1;                 // Reset
  bus_req_s    req = '0;                       // Bus request
  logic [31:0] bus_rdata, cmd_pulse, mode_cfg, tx_data, mem_rdata;
  logic        rx_valid = 1'b0;                // Receive strobe
  logic [31:0] rx_data = 32'h0;                // Received word
  logic        tx_ready = 1'b0;                // Function takes word
  logic        tx_valid, mem_ack, irq_source;
  mem_req_s    mem_req;                        // Channel request
  logic [3:0]  lat = 4'h0;                     // Memory latency
  int          mismatches = 0;                 // Failed checks
  int          n_tests = 0;                    // Checks made
  int          cycles = 0;                     // Clock count for timeout

  always #5 sys_clk = ~sys_clk;

  peripheral_register_shell i_peripheral_register_shell (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(bus_rdata),
    .cmd_pulse(cmd_pulse), .mode_cfg(mode_cfg), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq_source(irq_source));

  mem_model i_mem_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));

  ////////////////////////////////////////////////////////////////////////////
  // Shared checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Setup then access phase, no wait states
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge sys_clk) req = '{sel: 1'b1, enable: 1'b0, write: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk) req.enable = 1'b1;
    @(negedge sys_clk) req = '0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(negedge sys_clk) req = '{sel: 1'b1, enable: 1'b0, write: 1'b0, addr: a, wdata: 32'h0};
    @(negedge sys_clk) req.enable = 1'b1;
    check(bus_rdata, exp);
    @(negedge sys_clk) req = '0;
  endtask

  // One-cycle receive strobe
  task automatic rx_word(input logic [31:0] d);
    @(negedge sys_clk) rx_valid = 1'b1;
    rx_data = d;
    @(negedge sys_clk) rx_valid = 1'b0;
  endtask

  // Wait for one channel request to start and end, bounded
  task automatic wait_mem();
    int   n;
    logic started;  // Request seen before the first bound ran out
    n = 0;
    while (mem_req.valid !== 1'b1 && n < 50) begin
      @(negedge sys_clk) n++;
    end
    started = (mem_req.valid === 1'b1);
    while (mem_req.valid !== 1'b0 && n < 100) begin
      @(negedge sys_clk) n++;
    end
    check((started && n < 100) ? 32'h1 : 32'h0, 32'h1);
    repeat (3) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(BA + 32'h0c, 32'h02);
    rd(BA + 32'h04, 32'h0);
    rd(BA + 32'h20, 32'h0);
    check(irq_source, 1'b0);
  endtask

  task automatic t_mode();
    wr(BA + 32'h05, 32'ha5a5_5a5a);
    check(mode_cfg, 32'ha5a5_5a5a);
    rd(BA + 32'h3004, 32'ha5a5_5a5a);
    wr(BA + 32'h4004, 32'h0000_0001);
    rd(BA + 32'h06, 32'ha5a5_5a5a);
  endtask

  task automatic t_ctrl();
    wr(BA, 32'h8000_0001);
    check(cmd_pulse, 32'h8000_0001);
    @(negedge sys_clk) check(cmd_pulse, 32'h0);
    wr(BA, 32'h0);
    check(cmd_pulse, 32'h0);
    rd(BA, 32'h0);
  endtask

  task automatic t_status();
    wr(BA + 32'h10, 32'h0000_00f0);
    rd(BA + 32'h0c, 32'hf2);
    wr(BA + 32'h0c, 32'h0);
    rd(BA + 32'h0c, 32'hf2);
    wr(BA + 32'h14, 32'h0000_0030);
    rd(BA + 32'h0c, 32'hc2);
    wr(BA + 32'h10, 32'h0000_00ff);
    rd(BA + 32'h0c, 32'hff);
    wr(BA + 32'h14, 32'h0000_00ff);
    rd(BA + 32'h0c, 32'h02);
  endtask

  task automatic t_irq();
    wr(BA + 32'h10, 32'h10);
    check(irq_source, 1'b0);
    wr(BA + 32'h18, 32'h30);
    check(irq_source, 1'b1);
    rd(BA + 32'h20, 32'h30);
    wr(BA + 32'h1c, 32'h10);
    check(irq_source, 1'b0);
    rd(BA + 32'h20, 32'h20);
    wr(BA + 32'h1c, 32'h20);
    wr(BA + 32'h14, 32'h10);
  endtask

  task automatic t_data();
    rx_word(32'h1234_5678);
    rd(BA + 32'h0c, 32'h03);
    rd(BA + 32'h08, 32'h1234_5678);
    rd(BA + 32'h0c, 32'h02);
    wr(BA + 32'h08, 32'hcafe_f00d);
    check({tx_valid, tx_data[30:0]}, 32'hcafe_f00d);
    check(tx_data, 32'hcafe_f00d);
    rd(BA + 32'h0c, 32'h00);
    @(negedge sys_clk) tx_ready = 1'b1;
    @(negedge sys_clk) tx_ready = 1'b0;
    check(tx_valid, 1'b0);
  endtask

  task automatic t_chan();
    lat = 4'h3;
    wr(BA + 32'h30, 32'h0000_0100);
    wr(BA + 32'h34, 32'h0001_0002);
    rd(BA + 32'h34, 32'h2);
    rx_word(32'h0bad_0001);
    wait_mem();
    check(i_mem_model.last_addr, 32'h100);
    rx_word(32'h0bad_0002);
    wait_mem();
    check(i_mem_model.last_data, 32'h0bad_0002);
    check(i_mem_model.last_addr, 32'h101);
    rd(BA + 32'h34, 32'h0);
    rd(BA + 32'h30, 32'h102);
    rd(BA + 32'h0c, 32'h06);
    lat = 4'h0;
    wr(BA + 32'h38, 32'h0000_0200);
    wr(BA + 32'h3c, 32'h1);
    wait_mem();
    check(tx_data, ~32'h200);
    check(tx_valid, 1'b1);
    rd(BA + 32'h38, 32'h201);
    rd(BA + 32'h0c, 32'h0c);
  endtask

  // Reset in mid-run: registers other than the receive channel pointer, count and data word read back at defaults
  task automatic t_rst_mid();
    @(negedge sys_clk) sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    check({tx_valid, cmd_pulse[30:0]}, 32'h0);
    check(tx_data, 32'h0);
    t_reset();
    rd(BA + 32'h38, 32'h0);
    rd(BA + 32'h3c, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, timeout and main sequence
  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_mode();
    t_ctrl();
    t_status();
    t_irq();
    t_data();
    t_chan();
    t_rst_mid();
    final_report();
  end
endmodule

// [src/peripheral_register_shell.sv]
// Purpose: Common register, interrupt and transfer shell of a peripheral.
// Assumes: Bus slave with setup/access phases, no wait states.
// Notes:   Window aliases every 4 KB inside itself; only the low 12 bits decode.
`timescale 1ns/1ps
module peripheral_register_shell #(
  parameter logic [31:0] BASE     = 32'hfffc_0000,  // Window base address
  parameter int unsigned WIN_BITS = 14,             // 14: 16 KB, 12: 4 KB
  parameter int unsigned STEP     = 1               // Bytes per channel move
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Peripheral bus
  input  wire pshell_pkg::bus_req_s          bus_req,
  output logic      [pshell_pkg::DATA_W-1:0] bus_rdata,
  // Peripheral function side
  output logic      [pshell_pkg::DATA_W-1:0] cmd_pulse,
  output logic      [pshell_pkg::DATA_W-1:0] mode_cfg,
  input  wire logic                          rx_valid,
  input  wire logic [pshell_pkg::DATA_W-1:0] rx_data,
  output logic                               tx_valid,
  output logic      [pshell_pkg::DATA_W-1:0] tx_data,
  input  wire logic                          tx_ready,
  // Memory port of the transfer channels
  output pshell_pkg::mem_req_s               mem_req,
  input  wire logic                          mem_ack,
  input  wire logic [pshell_pkg::DATA_W-1:0] mem_rdata,
  // Interrupt source
  output logic                               irq_source
);
  import pshell_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic        hit;       // Address inside this window
  logic [11:0] off;       // Word-aligned offset
  logic        wr_cyc;    // Write access phase
  logic        rd_setup;  // Read setup phase (data registered here)
  logic        rd_cyc;    // Read access phase

  assign hit      = bus_req.sel &&
                    (bus_req.addr[31:WIN_BITS] == BASE[31:WIN_BITS]);
  assign off      = {bus_req.addr[11:2], 2'b00};
  assign wr_cyc   = hit && bus_req.enable && bus_req.write;
  assign rd_setup = hit && !bus_req.enable && !bus_req.write;
  assign rd_cyc   = hit && bus_req.enable && !bus_req.write;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [STATUS_W-1:0] sticky;     // Sticky status bits
  logic [STATUS_W-1:0] status_rd;  // Status as read
  logic [STATUS_W-1:0] mask;       // Interrupt mask
  logic [STATUS_W-1:0] hw_set;     // Status events from hardware
  logic [STATUS_W-1:0] sw_set;     // Set shadow write
  logic [STATUS_W-1:0] sw_clr;     // Clear shadow write and read side effect
  logic [DATA_W-1:0]   rx_word;    // Last received word
  logic                rx_full;    // Received word owed to memory
  mem_state_e          mstate;     // Memory port state

  // Channel wiring
  logic [DATA_W-1:0] ch_ptr    [N_CHAN];
  logic [CNT_W-1:0]  ch_cnt    [N_CHAN];
  logic [N_CHAN-1:0] ch_active;  // Count non-zero
  logic [N_CHAN-1:0] ch_done;    // Last word moved
  logic [N_CHAN-1:0] ch_move;    // Word moved this cycle
  logic [N_CHAN-1:0] ch_ptr_wr;  // Pointer register written
  logic [N_CHAN-1:0] ch_cnt_wr;  // Count register written

  ////////////////////////////////////////////////////////////////////////////
  // Transfer channels, one receive and one transmit
  assign ch_ptr_wr[CH_RX] = wr_cyc && (off == OFF_RXPTR);
  assign ch_cnt_wr[CH_RX] = wr_cyc && (off == OFF_RXCNT);
  assign ch_ptr_wr[CH_TX] = wr_cyc && (off == OFF_TXPTR);
  assign ch_cnt_wr[CH_TX] = wr_cyc && (off == OFF_TXCNT);
  assign ch_move[CH_RX]   = (mstate == MP_STORE) && mem_ack;
  assign ch_move[CH_TX]   = (mstate == MP_LOAD) && mem_ack;

  genvar gi;
  generate
    for (gi = 0; gi < N_CHAN; gi++) begin : g_chan
      // One channel per direction
      xfer_channel #(.STEP(STEP)) u_chan (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ptr_wr  (ch_ptr_wr[gi]),
        .cnt_wr  (ch_cnt_wr[gi]),
        .wdata   (bus_req.wdata),
        .move    (ch_move[gi]),
        .ptr     (ch_ptr[gi]),
        .cnt     (ch_cnt[gi]),
        .active  (ch_active[gi]),
        .done    (ch_done[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Command register: one-cycle pulse per written one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_pulse <= WORD_ZERO;
    end else if (wr_cyc && (off == OFF_CTRL)) begin
      cmd_pulse <= bus_req.wdata;
    end else begin
      cmd_pulse <= WORD_ZERO;
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_cfg <= MODE_RST;
    end else if (wr_cyc && (off == OFF_MODE)) begin
      mode_cfg <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status events; a hardware or shadow set beats a clear in the same cycle
  always_comb begin
    hw_set           = STATUS_RST;
    hw_set[ST_RXRDY] = rx_valid && !ch_active[CH_RX];
    hw_set[ST_ENDRX] = ch_done[CH_RX];
    hw_set[ST_ENDTX] = ch_done[CH_TX];
    sw_set           = (wr_cyc && (off == OFF_SSET)) ?
                       bus_req.wdata[STATUS_W-1:0] : STATUS_RST;
    sw_clr           = (wr_cyc && (off == OFF_SCLR)) ?
                       bus_req.wdata[STATUS_W-1:0] : STATUS_RST;
    if (rd_cyc && (off == OFF_DATA)) begin
      sw_clr[ST_RXRDY] = 1'b1;  // Reading the word consumes it
    end
  end

  // Sticky status; writes to the status offset itself do nothing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sticky <= STATUS_RST;
    end else begin
      sticky <= ((sticky & ~sw_clr) | sw_set | hw_set) & STICKY_MASK;
    end
  end

  // Live transmit-free bit joins the sticky bits
  always_comb begin
    status_rd           = sticky;
    status_rd[ST_TXRDY] = !tx_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask: enable sets, disable clears, enable wins on overlap
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= MASK_RST;
    end else begin
      mask <= (mask & ~((wr_cyc && (off == OFF_IDIS)) ?
                        bus_req.wdata[STATUS_W-1:0] : STATUS_RST))
              | ((wr_cyc && (off == OFF_IEN)) ?
                 bus_req.wdata[STATUS_W-1:0] : STATUS_RST);
    end
  end

  // Masked OR forms the interrupt source
  assign irq_source = |(status_rd & mask);

  ////////////////////////////////////////////////////////////////////////////
  // Receive word capture and channel ownership flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word <= WORD_ZERO;
    end else if (rx_valid) begin
      rx_word <= rx_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_full <= 1'b0;
    end else if (rx_valid && ch_active[CH_RX]) begin
      rx_full <= 1'b1;  // New arrival wins over a store finishing
    end else if (ch_move[CH_RX]) begin
      rx_full <= 1'b0;
    end
  end

  // Transmit holding register, fed by software or by the channel
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data  <= WORD_ZERO;
    end else if (ch_move[CH_TX]) begin
      tx_valid <= 1'b1;
      tx_data  <= mem_rdata;
    end else if (wr_cyc && (off == OFF_DATA) && !ch_active[CH_TX]) begin
      tx_valid <= 1'b1;
      tx_data  <= bus_req.wdata;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;  // Function took the word
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port sequencer, receive store has priority
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mstate  <= MP_IDLE;
      mem_req <= '0;
    end else begin
      case (mstate)
        MP_IDLE: begin
          if (rx_full && ch_active[CH_RX]) begin
            mstate  <= MP_STORE;
            mem_req <= '{valid: 1'b1, write: 1'b1, addr: ch_ptr[CH_RX], wdata: rx_word};
          end else if (ch_active[CH_TX] && !tx_valid) begin
            mstate  <= MP_LOAD;
            mem_req <= '{valid: 1'b1, write: 1'b0, addr: ch_ptr[CH_TX], wdata: WORD_ZERO};
          end
        end
        MP_STORE, MP_LOAD: begin
          if (mem_ack) begin
            mstate  <= MP_IDLE;
            mem_req <= '0;
          end
        end
        default: begin
          mstate  <= MP_IDLE;
          mem_req <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the setup phase; unused bits read zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= WORD_ZERO;
    end else if (rd_setup) begin
      case (off)
        OFF_MODE:   bus_rdata <= mode_cfg;
        OFF_DATA:   bus_rdata <= rx_word;
        OFF_STATUS: bus_rdata <= {{(DATA_W-STATUS_W){1'b0}}, status_rd};
        OFF_IMASK:  bus_rdata <= {{(DATA_W-STATUS_W){1'b0}}, mask};
        OFF_RXPTR:  bus_rdata <= ch_ptr[CH_RX];
        OFF_RXCNT:  bus_rdata <= {{(DATA_W-CNT_W){1'b0}}, ch_cnt[CH_RX]};
        OFF_TXPTR:  bus_rdata <= ch_ptr[CH_TX];
        OFF_TXCNT:  bus_rdata <= {{(DATA_W-CNT_W){1'b0}}, ch_cnt[CH_TX]};
        default:    bus_rdata <= WORD_ZERO;  // Write-only and unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CMD_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_CTRL) |=> cmd_pulse == $past(bus_req.wdata) ##1 cmd_pulse == '0)
    else $error("command pulse wrong");

  AST_MODE_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_MODE) |=> mode_cfg == $past(bus_req.wdata))
    else $error("mode write lost");

  AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_STATUS) && hw_set == '0 |=> $stable(sticky))
    else $error("status changed by write");

  AST_SET_SHADOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_SSET) |=>
      (sticky & $past(bus_req.wdata[STATUS_W-1:0] & STICKY_MASK))
      == $past(bus_req.wdata[STATUS_W-1:0] & STICKY_MASK))
    else $error("set shadow missed");

  AST_CLR_SHADOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_SCLR) && hw_set == '0 |=>
      (sticky & $past(bus_req.wdata[STATUS_W-1:0])) == '0)
    else $error("clear shadow missed");

  AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_setup && (off == OFF_STATUS || off == OFF_IMASK) |=> bus_rdata[31:STATUS_W] == '0)
    else $error("unused bits not zero");

  AST_IRQ_OR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_source |-> (sticky & mask) != '0 || (mask[ST_TXRDY] && !tx_valid))
    else $error("interrupt without cause");

  AST_MASK_EN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cyc && (off == OFF_IEN) |=>
      (mask & $past(bus_req.wdata[STATUS_W-1:0])) == $past(bus_req.wdata[STATUS_W-1:0]))
    else $error("mask enable missed");

  AST_END_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ch_move[CH_RX] && !ch_cnt_wr[CH_RX] && ch_cnt[CH_RX] == 16'h0001
      |=> ##1 sticky[ST_ENDRX])
    else $error("end of receive not flagged");

  AST_CNT_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ch_move[CH_TX] && !ch_cnt_wr[CH_TX] && !ch_ptr_wr[CH_TX] |=>
      ch_cnt[CH_TX] == $past(ch_cnt[CH_TX]) - 16'h0001 &&
      ch_ptr[CH_TX] == $past(ch_ptr[CH_TX]) + 32'(STEP))
    else $error("channel step wrong");

endmodule

// [src/pshell_pkg.sv]
// Purpose: Shared constants and carriers for the peripheral register shell.
// Assumes: 32-bit peripheral bus, word-only register access.
// Notes:   Offsets are byte offsets inside the peripheral window.
package pshell_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned DATA_W   = 32;   // Bus data width
  localparam int unsigned STATUS_W = 8;    // Implemented status / mask bits
  localparam int unsigned CNT_W    = 16;   // Transfer count width
  localparam int unsigned N_CHAN   = 2;    // Receive and transmit channel
  localparam int unsigned CH_RX    = 0;    // Channel index of the receiver
  localparam int unsigned CH_TX    = 1;    // Channel index of the transmitter

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (low 12 address bits, word aligned)
  localparam logic [11:0] OFF_CTRL   = 12'h000;  // Command, write-only
  localparam logic [11:0] OFF_MODE   = 12'h004;  // Configuration
  localparam logic [11:0] OFF_DATA   = 12'h008;  // Receive / transmit data
  localparam logic [11:0] OFF_STATUS = 12'h00c;  // Status, read-only
  localparam logic [11:0] OFF_SSET   = 12'h010;  // Status set shadow
  localparam logic [11:0] OFF_SCLR   = 12'h014;  // Status clear shadow
  localparam logic [11:0] OFF_IEN    = 12'h018;  // Mask enable
  localparam logic [11:0] OFF_IDIS   = 12'h01c;  // Mask disable
  localparam logic [11:0] OFF_IMASK  = 12'h020;  // Mask readback
  localparam logic [11:0] OFF_RXPTR  = 12'h030;  // Receive channel pointer
  localparam logic [11:0] OFF_RXCNT  = 12'h034;  // Receive channel count
  localparam logic [11:0] OFF_TXPTR  = 12'h038;  // Transmit channel pointer
  localparam logic [11:0] OFF_TXCNT  = 12'h03c;  // Transmit channel count

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions and reset values
  localparam int unsigned ST_RXRDY = 0;  // Receive word waiting
  localparam int unsigned ST_TXRDY = 1;  // Transmit holding free (live)
  localparam int unsigned ST_ENDRX = 2;  // Receive channel finished
  localparam int unsigned ST_ENDTX = 3;  // Transmit channel finished
  localparam logic [STATUS_W-1:0] STICKY_MASK = 8'hfd;       // All but TXRDY
  localparam logic [STATUS_W-1:0] STATUS_RST  = 8'h00;
  localparam logic [STATUS_W-1:0] MASK_RST    = 8'h00;
  localparam logic [DATA_W-1:0]   MODE_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0]   WORD_ZERO   = 32'h0000_0000;
  localparam logic [CNT_W-1:0]    CNT_RST     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic              sel;     // Peripheral selected by system decoder
    logic              enable;  // Access phase
    logic              write;   // 1 write, 0 read
    logic [DATA_W-1:0] addr;    // Byte address
    logic [DATA_W-1:0] wdata;   // Write data
  } bus_req_s;

  typedef struct packed {
    logic              valid;   // Request pending
    logic              write;   // 1 store to memory, 0 load
    logic [DATA_W-1:0] addr;    // Memory byte address
    logic [DATA_W-1:0] wdata;   // Store data
  } mem_req_s;

  // Memory port sequencer, Gray coded along idle -> store / idle -> load
  typedef enum logic [1:0] {
    MP_IDLE  = 2'b00,
    MP_STORE = 2'b01,
    MP_LOAD  = 2'b10
  } mem_state_e;

endpackage

// [src/xfer_channel.sv]
// Purpose: One pointer/count transfer channel.
// Assumes: Caller only pulses move while the channel is active.
// Notes:   Register writes win over a move in the same cycle.
`timescale 1ns/1ps
module xfer_channel #(
  parameter int unsigned STEP = 1  // Bytes advanced per move
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Register writes
  input  wire logic                          ptr_wr,
  input  wire logic                          cnt_wr,
  input  wire logic [pshell_pkg::DATA_W-1:0] wdata,
  // Data movement
  input  wire logic                          move,
  output logic      [pshell_pkg::DATA_W-1:0] ptr,
  output logic      [pshell_pkg::CNT_W-1:0]  cnt,
  output logic                               active,
  output logic                               done
);
  import pshell_pkg::*;

  localparam logic [DATA_W-1:0] STEP_W = DATA_W'(STEP);  // Pointer step
  localparam logic [CNT_W-1:0]  ONE    = 16'h0001;       // Count step

  // Channel runs while words remain
  assign active = (cnt != CNT_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer: load or advance by one transfer size
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr <= WORD_ZERO;
    end else if (ptr_wr) begin
      ptr <= wdata;
    end else if (move && active) begin
      ptr <= ptr + STEP_W;
    end
  end

  // Count: 16 bits bound one run to 65535 moves
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= CNT_RST;
    end else if (cnt_wr) begin
      cnt <= wdata[CNT_W-1:0];
    end else if (move && active) begin
      cnt <= cnt - ONE;
    end
  end

  // End pulse when the last word moves
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
    end else begin
      done <= move && !cnt_wr && (cnt == ONE);
    end
  end

endmodule
